// ### core/mdsio_pkg.sv
// package for the motor driver status and sensor i/o block
// assumes a 20 MHz sys_clk and an apb master on the same clock
// Summary of operation
// [R01] upper above lower: zone on while lower <= position <= upper
// [R02] upper equal lower: zone on only when position equals the bound
// [R03] upper below lower: zone on when position <= upper or >= lower
// [R04] zones 1 and 2 watch commanded position, zone 3 actual position
// [R05] timing pulse once per 7.2 degrees, fifty per shaft revolution
// [R06] timing pulse only trusted up to 30 r/min commanded speed
// [R07] user should set step resolution to a multiple of fifty
// [R08] busy output held while internal or maintenance processing runs
// [R09] main power status output on while main supply is on
// [R10] every listed input has an echo output following its level
// [R11] echoes of motion inputs show input level only, not motion
// [R12] limits during homing go to the homing logic, not overtravel
// [R13] limits outside homing flag hardware overtravel and stop motor
// [R14] overtravel detection setting, 0 disable 1 enable, default enable
// [R15] overtravel stop setting, 0 immediate 1 decelerate, default 0
// [R16] limit polarity setting, 0 normally open 1 normally closed
// [R17] home sensor is mechanical home reference in three-sensor mode
// [R18] home sensor polarity setting, 0 open 1 closed, default 0
// [R19] slit sensor aids homing, own polarity setting, default 0
// [R20] routed fieldbus input bit drives direct output pin on/off
// [R21] routed direct input pin, after polarity, reports on fieldbus bit
// [R22] echoes and routing add no latency beyond input sampling; the code adds one register stage after the two-flop synchroniser
package mdsio_pkg;
   localparam int          POS_W        = 24;
   localparam int          CMD_IN_W     = 23;
   localparam int          N_ZONE       = 3;
   localparam int          N_ROUTE      = 16;
   localparam int          N_DIN        = 6;
   localparam int          N_DOUT       = 6;
   localparam int          PULSES_REV   = 50;
   localparam int          STEPS_REV    = 1000;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_ZONE     = 8'h04;
   localparam logic [7:0]  OFS_FB_IN    = 8'h1C;
   localparam logic [7:0]  OFS_RT_OUT   = 8'h20;
   localparam logic [7:0]  OFS_RT_IN    = 8'h24;
   localparam logic [7:0]  OFS_IN_POL   = 8'h28;
   localparam logic [7:0]  OFS_FB_OUT   = 8'h2C;
   localparam logic [7:0]  OFS_STATUS   = 8'h30;
   localparam logic [7:0]  OFS_ECHO     = 8'h34;
   // control field positions
   localparam int          CB_OT_EN     = 0;
   localparam int          CB_OT_DEC    = 1;
   localparam int          CB_LS_NC     = 2;
   localparam int          CB_HOME_SENSOR_IN_NC  = 3;
   localparam int          CB_SLIT_NC   = 4;
   localparam int          CB_THREE_SNS = 5;
   localparam int          CB_MAINT     = 6;
   localparam int          CTRL_W       = 7;
   localparam logic [6:0]  CTRL_RST     = 7'h01;
   // status field positions
   localparam int          SB_OT_FLAG   = 8;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

   typedef struct packed {
      logic pos_lim;
      logic neg_lim;
      logic home_sensor_in;
      logic slit;
   } mdsio_sensor_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } mdsio_apb_rsp_t;

   function automatic logic in_zone(input logic signed [POS_W-1:0] pos,
                                    input logic signed [POS_W-1:0] up,
                                    input logic signed [POS_W-1:0] lo);
      if (up > lo) begin
         return (pos >= lo) && (pos <= up);  // see [R01]
      end else if (up == lo) begin
         return pos == up;  // see [R02]
      end
      return (pos <= up) || (pos >= lo);  // see [R03]
   endfunction : in_zone
endpackage : mdsio_pkg

// ### core/mdsio_top.sv
// status outputs, sensor inputs and general routing of a motor driver
// assumes pins arrive unsynchronised; positions and step events are
// from motion logic on sys_clk
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module mdsio_top
   import mdsio_pkg::*;
#(
   parameter int STEPS_PER_REV = STEPS_REV
) (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // apb slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output      logic [31:0]             prdata,
   output      logic                    pready,
   output      logic                    pslverr,
   // motion core, same clock
   input  wire logic signed [POS_W-1:0] cmd_pos,
   input  wire logic signed [POS_W-1:0] act_pos,
   input  wire logic                    step_evt,
   input  wire logic                    step_dir,
   input  wire logic                    home_op_active,
   input  wire logic                    internal_busy,
   // pins
   input  wire logic [CMD_IN_W-1:0]     cmd_in_pins,
   input  wire mdsio_sensor_t           sensor_pins,
   input  wire logic [N_DIN-1:0]        direct_in_pins,
   input  wire logic                    main_power_on,
   // outputs
   output      logic [N_ZONE-1:0]       zone_compare_out,
   output      logic                    shaft_angle_pulse,
   output      logic                    maintenance_busy_out,
   output      logic                    main_power_status_out,
   output      logic [CMD_IN_W-1:0]     cmd_echo_out,
   output      mdsio_sensor_t           sensor_echo_out,
   output      logic                    ot_stop_immediate,
   output      logic                    ot_stop_decel,
   output      logic                    homing_limit_pos,
   output      logic                    homing_limit_neg,
   output      logic                    home_ref_out,
   output      logic                    slit_ref_out,
   output      logic [N_DOUT-1:0]       direct_out_pins,
   output      logic [N_ROUTE-1:0]      fieldbus_out
);
   localparam int STEPS_PER_TIM = STEPS_PER_REV / PULSES_REV;
   localparam int SYNC_W        = CMD_IN_W + 4 + N_DIN + 1;

   // pin synchroniser, two flops; nothing but sync2 reads sync1
   logic [SYNC_W-1:0] sync1_reg, sync2_reg;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {cmd_in_pins, sensor_pins, direct_in_pins, main_power_on};
         sync2_reg <= sync1_reg;
      end
   end
   logic [CMD_IN_W-1:0] cmd_s;
   mdsio_sensor_t       sns_s;
   logic [N_DIN-1:0]    din_s;
   logic                mpwr_s;
   assign {cmd_s, sns_s, din_s, mpwr_s} = sync2_reg;

   // software state
   logic [CTRL_W-1:0]      ctrl_reg, ctrl_next;
   logic [POS_W-1:0]       zup_reg [N_ZONE], zup_next [N_ZONE];
   logic [POS_W-1:0]       zlo_reg [N_ZONE], zlo_next [N_ZONE];
   logic [N_ROUTE-1:0]     fb_in_reg, fb_in_next;
   logic [5*N_DOUT-1:0]    rt_out_reg, rt_out_next;
   logic [5*N_DIN-1:0]     rt_in_reg, rt_in_next;
   logic [N_DIN-1:0]       in_pol_reg, in_pol_next;
   logic                   ot_flag_reg, ot_flag_next;
   mdsio_apb_rsp_t         rsp_reg, rsp_next;

   // status state
   logic [N_ZONE-1:0]      zone_reg, zone_next;
   logic [$clog2(STEPS_PER_TIM+1)-1:0] tim_cnt_reg, tim_cnt_next;
   logic                   tim_reg, tim_next;
   logic                   busy_reg, mps_reg;
   logic [CMD_IN_W-1:0]    cmd_echo_reg;
   mdsio_sensor_t          sns_echo_reg;
   logic                   ot_imm_reg, ot_dec_reg, ot_imm_next, ot_dec_next;
   logic                   hl_pos_reg, hl_neg_reg, home_reg, slit_reg;
   logic [N_DOUT-1:0]      dout_reg, dout_next;
   logic [N_ROUTE-1:0]     fbo_reg, fbo_next;

   // sensor levels after polarity
   logic pos_act, neg_act, home_sensor_in_act, slit_act, ot_hit;
   logic [N_DIN-1:0] din_act;
   always_comb begin
      pos_act   = sns_s.pos_lim ^ ctrl_reg[CB_LS_NC];  // see [R16]
      neg_act   = sns_s.neg_lim ^ ctrl_reg[CB_LS_NC];  // see [R16]
      home_sensor_in_act = sns_s.home_sensor_in ^ ctrl_reg[CB_HOME_SENSOR_IN_NC];  // see [R18]
      slit_act  = sns_s.slit ^ ctrl_reg[CB_SLIT_NC];  // see [R19]
      din_act   = din_s ^ in_pol_reg;  // see [R21]
      // homing owns the limits, otherwise they mean overtravel
      ot_hit    = ctrl_reg[CB_OT_EN] && !home_op_active
                  && (pos_act || neg_act);  // see [R13] see [R14] see [R12]
   end

   // apb access and register writes
   logic        acc, wr_acc;
   logic [31:0] rd_word;
   logic        mapped;
   always_comb begin
      acc          = psel && penable && !rsp_reg.pready;
      wr_acc       = psel && penable && rsp_reg.pready && pwrite;
      ctrl_next    = ctrl_reg;
      fb_in_next   = fb_in_reg;
      rt_out_next  = rt_out_reg;
      rt_in_next   = rt_in_reg;
      in_pol_next  = in_pol_reg;
      zup_next     = zup_reg;
      zlo_next     = zlo_reg;
      rd_word      = WORD_ZERO;
      mapped       = 1'b1;
      // hardware set beats a software clear in the same cycle
      ot_flag_next = ot_flag_reg;
      if (wr_acc && paddr == OFS_STATUS && pwdata[SB_OT_FLAG]) begin
         ot_flag_next = 1'b0;
      end
      if (ot_hit) begin
         ot_flag_next = 1'b1;  // see [R13]
      end
      unique case (paddr)
         OFS_CTRL:   rd_word = {25'h000_0000, ctrl_reg};
         OFS_FB_IN:  rd_word = {16'h0000, fb_in_reg};
         OFS_RT_OUT: rd_word = {2'b00, rt_out_reg};
         OFS_RT_IN:  rd_word = {2'b00, rt_in_reg};
         OFS_IN_POL: rd_word = {26'h000_0000, in_pol_reg};
         OFS_FB_OUT: rd_word = {16'h0000, fbo_reg};
         OFS_STATUS: rd_word = {23'h00_0000, ot_flag_reg, mps_reg, busy_reg,
                                ot_imm_reg, ot_dec_reg, tim_reg, zone_reg};
         OFS_ECHO:   rd_word = {5'h00, sns_echo_reg, cmd_echo_reg};
         default: begin
            mapped = 1'b0;
            for (int i = 0; i < N_ZONE; i++) begin
               if (paddr == OFS_ZONE + 8'(8 * i)) begin
                  rd_word = 32'(signed'(zup_reg[i]));
                  mapped  = 1'b1;
               end
               if (paddr == OFS_ZONE + 8'(8 * i + 4)) begin
                  rd_word = 32'(signed'(zlo_reg[i]));
                  mapped  = 1'b1;
               end
            end
         end
      endcase
      if (wr_acc) begin
         unique case (paddr)
            OFS_CTRL:   ctrl_next   = pwdata[CTRL_W-1:0];  // see [R14] see [R15]
            OFS_FB_IN:  fb_in_next  = pwdata[N_ROUTE-1:0];
            OFS_RT_OUT: rt_out_next = pwdata[5*N_DOUT-1:0];
            OFS_RT_IN:  rt_in_next  = pwdata[5*N_DIN-1:0];
            OFS_IN_POL: in_pol_next = pwdata[N_DIN-1:0];
            default: begin
               for (int i = 0; i < N_ZONE; i++) begin
                  if (paddr == OFS_ZONE + 8'(8 * i)) begin
                     zup_next[i] = pwdata[POS_W-1:0];
                  end
                  if (paddr == OFS_ZONE + 8'(8 * i + 4)) begin
                     zlo_next[i] = pwdata[POS_W-1:0];
                  end
               end
            end
         endcase
      end
      // one wait state: answer on the second access edge
      rsp_next.pready  = acc;
      rsp_next.pslverr = acc && !mapped;
      rsp_next.prdata  = (acc && !pwrite) ? rd_word : WORD_ZERO;
   end

   // zones, timing pulse, stops and routing
   always_comb begin
      zone_next[0] = in_zone(cmd_pos, zup_reg[0], zlo_reg[0]);  // see [R04]
      zone_next[1] = in_zone(cmd_pos, zup_reg[1], zlo_reg[1]);  // see [R04]
      zone_next[2] = in_zone(act_pos, zup_reg[2], zlo_reg[2]);  // see [R04]
      // step counter tracks the commanded shaft angle; one step per
      // cycle at most, so fast speeds can alias
      tim_cnt_next = tim_cnt_reg;
      if (step_evt) begin
         if (step_dir) begin
            tim_cnt_next = (tim_cnt_reg == STEPS_PER_TIM - 1) ? '0 : tim_cnt_reg + 1'b1;
         end else begin
            tim_cnt_next = (tim_cnt_reg == 0) ? ($bits(tim_cnt_reg))'(STEPS_PER_TIM - 1)
                                              : tim_cnt_reg - 1'b1;
         end
      end
      tim_next    = (tim_cnt_next == 0);  // see [R05] see [R06]
      ot_imm_next = ot_hit && !ctrl_reg[CB_OT_DEC];  // see [R15]
      ot_dec_next = ot_hit && ctrl_reg[CB_OT_DEC];  // see [R15]
      for (int k = 0; k < N_DOUT; k++) begin
         dout_next[k] = rt_out_reg[5*k+4] && fb_in_reg[rt_out_reg[5*k +: 4]];  // see [R20]
      end
      fbo_next = '0;
      for (int p = 0; p < N_DIN; p++) begin
         if (rt_in_reg[5*p+4] && din_act[p]) begin
            fbo_next[rt_in_reg[5*p +: 4]] = 1'b1;  // see [R21]
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_reg     <= CTRL_RST;
         fb_in_reg    <= '0;
         rt_out_reg   <= '0;
         rt_in_reg    <= '0;
         in_pol_reg   <= '0;
         ot_flag_reg  <= 1'b0;
         rsp_reg      <= '0;
         for (int i = 0; i < N_ZONE; i++) begin
            zup_reg[i] <= '0;
            zlo_reg[i] <= '0;
         end
         zone_reg     <= '0;
         tim_cnt_reg  <= '0;
         tim_reg      <= 1'b0;
         busy_reg     <= 1'b0;
         mps_reg      <= 1'b0;
         cmd_echo_reg <= '0;
         sns_echo_reg <= '0;
         ot_imm_reg   <= 1'b0;
         ot_dec_reg   <= 1'b0;
         hl_pos_reg   <= 1'b0;
         hl_neg_reg   <= 1'b0;
         home_reg     <= 1'b0;
         slit_reg     <= 1'b0;
         dout_reg     <= '0;
         fbo_reg      <= '0;
      end else begin
         ctrl_reg     <= ctrl_next;
         fb_in_reg    <= fb_in_next;
         rt_out_reg   <= rt_out_next;
         rt_in_reg    <= rt_in_next;
         in_pol_reg   <= in_pol_next;
         ot_flag_reg  <= ot_flag_next;
         rsp_reg      <= rsp_next;
         zup_reg      <= zup_next;
         zlo_reg      <= zlo_next;
         zone_reg     <= zone_next;
         tim_cnt_reg  <= tim_cnt_next;
         tim_reg      <= tim_next;
         busy_reg     <= internal_busy || ctrl_reg[CB_MAINT];  // see [R08]
         mps_reg      <= mpwr_s;  // see [R09]
         cmd_echo_reg <= cmd_s;  // see [R10] see [R11] see [R22]
         sns_echo_reg <= sns_s;  // see [R10] see [R22]
         ot_imm_reg   <= ot_imm_next;
         ot_dec_reg   <= ot_dec_next;
         hl_pos_reg   <= home_op_active && pos_act;  // see [R12]
         hl_neg_reg   <= home_op_active && neg_act;  // see [R12]
         home_reg     <= ctrl_reg[CB_THREE_SNS] && home_sensor_in_act;  // see [R17]
         slit_reg     <= slit_act;  // see [R19]
         dout_reg     <= dout_next;
         fbo_reg      <= fbo_next;
      end
   end

   assign prdata                = rsp_reg.prdata;
   assign pready                = rsp_reg.pready;
   assign pslverr               = rsp_reg.pslverr;
   assign zone_compare_out      = zone_reg;
   assign shaft_angle_pulse     = tim_reg;
   assign maintenance_busy_out  = busy_reg;
   assign main_power_status_out = mps_reg;
   assign cmd_echo_out          = cmd_echo_reg;
   assign sensor_echo_out       = sns_echo_reg;
   assign ot_stop_immediate     = ot_imm_reg;
   assign ot_stop_decel         = ot_dec_reg;
   assign homing_limit_pos      = hl_pos_reg;
   assign homing_limit_neg      = hl_neg_reg;
   assign home_ref_out          = home_reg;
   assign slit_ref_out          = slit_reg;
   assign direct_out_pins       = dout_reg;
   assign fieldbus_out          = fbo_reg;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // bounds are stored unsigned, so every ordered compare casts them back to signed
   a_zone_inside: assert property (  // see [R01]
      signed'(zup_reg[0]) > signed'(zlo_reg[0])
      |=> zone_reg[0] == ($past(cmd_pos) >= signed'($past(zlo_reg[0]))
                          && $past(cmd_pos) <= signed'($past(zup_reg[0]))))
      else $error("zone 1 window wrong");
   a_zone_equal: assert property (  // see [R02]
      zup_reg[2] == zlo_reg[2] && act_pos != signed'(zup_reg[2])
      |=> !zone_reg[2])
      else $error("zone 3 on off the exact bound");
   a_zone_wrap: assert property (  // see [R03]
      signed'(zup_reg[1]) < signed'(zlo_reg[1]) && cmd_pos > signed'(zup_reg[1])
      && cmd_pos < signed'(zlo_reg[1]) |=> !zone_reg[1])
      else $error("zone 2 on inside the gap");
   a_tim_period: assert property (  // see [R05]
      step_evt && step_dir && tim_cnt_reg == STEPS_PER_TIM - 1 |=> tim_reg)
      else $error("timing pulse missed at angle boundary");
   a_busy_held: assert property (  // see [R08]
      internal_busy |=> busy_reg)
      else $error("busy dropped during processing");
   // three flops from pin to echo, none of them in reset
   a_echo_follow: assert property (  // see [R10]
      !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
      |-> cmd_echo_out == $past(cmd_in_pins, 3))
      else $error("echo lags input");
   a_ot_stop: assert property (  // see [R13]
      ctrl_reg[CB_OT_EN] && !home_op_active && pos_act && !ctrl_reg[CB_OT_DEC]
      |=> ot_stop_immediate && !ot_stop_decel)
      else $error("overtravel stop missing");
   a_ot_homing: assert property (  // see [R12]
      home_op_active |=> !ot_stop_immediate && !ot_stop_decel)
      else $error("overtravel raised during homing");
   a_ot_disabled: assert property (  // see [R14]
      !ctrl_reg[CB_OT_EN] |=> !ot_stop_immediate && !ot_stop_decel)
      else $error("overtravel raised while disabled");
   a_route_out: assert property (  // see [R20]
      rt_out_reg[4] |=> direct_out_pins[0] == $past(fb_in_reg[rt_out_reg[3:0]]))
      else $error("routed output pin wrong");
   a_apb_answer: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not one cycle");

   c_zone_hit:  cover property (zone_reg[0] ##1 !zone_reg[0]);
   c_tim_pulse: cover property (!tim_reg ##1 tim_reg);
   c_ot_decel:  cover property (ot_stop_decel);
   c_route_in:  cover property (|fieldbus_out);
endmodule : mdsio_top

// ### dv/mdsio_sensor_model.sv
// contact model for the limit, home and slit switches at the far side
// assumes the bench gives the physical switch state, in step with sys_clk
`timescale 1ns/1ps
module mdsio_sensor_model
   import mdsio_pkg::*;
(
   // clock
   input  wire logic          sys_clk,
   // switch state, 1 = actuated
   input  wire logic [3:0]    act,
   // contact type per switch, 1 = normally closed
   input  wire logic [3:0]    nc,
   // raw pins, order pos, neg, home, slit
   output      mdsio_sensor_t pins
);
   // a closed contact opens when actuated, so its pin level inverts
   always_ff @(posedge sys_clk) begin
      pins <= mdsio_sensor_t'(act ^ nc);
   end
endmodule : mdsio_sensor_model

// ### dv/test_motor_driver_status_and_sensor_io.sv
// self-checking bench for the status and sensor i/o block
// assumes an apb master and the sensor model on one 20 MHz clock
`timescale 1ns/1ps
module test_motor_driver_status_and_sensor_io;
   import mdsio_pkg::*;
   localparam int STEPS = 100;  // resolution a multiple of fifty
   typedef struct {int sel; logic [31:0] exp; logic err;} mdsio_note_t;
   logic                    sys_clk, rst, psel, penable, pwrite, step_evt, step_dir;
   logic                    home_op_active, internal_busy, main_power_on, pready, pslverr;
   logic [7:0]              paddr;
   logic [31:0]             pwdata, prdata;
   logic signed [POS_W-1:0] cmd_pos, act_pos;
   logic [CMD_IN_W-1:0]     cmd_in_pins, cmd_echo_out;
   mdsio_sensor_t           sensor_pins, sensor_echo_out;
   logic [N_DIN-1:0]        direct_in_pins;
   logic [N_DOUT-1:0]       direct_out_pins;
   logic [N_ZONE-1:0]       zone_compare_out;
   logic [N_ROUTE-1:0]      fieldbus_out;
   logic                    shaft_angle_pulse, maintenance_busy_out, main_power_status_out;
   logic                    ot_stop_immediate, ot_stop_decel, homing_limit_pos;
   logic                    homing_limit_neg, home_ref_out, slit_ref_out, counting, pulse_d;
   logic [3:0]              sw_act, sw_nc;
   int                      failures, checks, rises, seed = 13;
   int                      up_t[3] = '{100, 7, -20};
   int                      lo_t[3] = '{-50, 7, 30};
   mdsio_note_t             q_rd[$], q_lvl[$];
   event                    obs_ev;

   mdsio_top #(.STEPS_PER_REV(STEPS)) mdsio_top_inst (
      .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .cmd_pos, .act_pos, .step_evt, .step_dir, .home_op_active, .internal_busy,
      .cmd_in_pins, .sensor_pins, .direct_in_pins, .main_power_on,
      .zone_compare_out, .shaft_angle_pulse, .maintenance_busy_out, .main_power_status_out,
      .cmd_echo_out, .sensor_echo_out, .ot_stop_immediate, .ot_stop_decel,
      .homing_limit_pos, .homing_limit_neg, .home_ref_out, .slit_ref_out,
      .direct_out_pins, .fieldbus_out);
   mdsio_sensor_model mdsio_sensor_model_inst (.sys_clk, .act(sw_act), .nc(sw_nc),
      .pins(sensor_pins));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   function automatic logic zin(input int p, input int u, input int l);
      if (u > l) return p >= l && p <= u;
      if (u == l) return p == u;
      return p <= u || p >= l;
   endfunction : zin

   function automatic logic [31:0] obs(input int s);
      case (s)
         0: return 32'(zone_compare_out);
         1: return 32'(cmd_echo_out);
         2: return 32'(sensor_echo_out);
         3: return {30'h0000_0000, ot_stop_immediate, ot_stop_decel};
         4: return 32'(fieldbus_out);
         5: return 32'(direct_out_pins);
         6: return {30'h0000_0000, maintenance_busy_out, main_power_status_out};
         7: return {28'h000_0000, homing_limit_pos, homing_limit_neg, home_ref_out, slit_ref_out};
         default: return 32'(rises);
      endcase
   endfunction : obs

   task automatic chk_rd(input logic [31:0] got, input logic gerr, input mdsio_note_t n);
      checks++;
      if (got !== n.exp || gerr !== n.err) begin
         failures++;
         $display("CHECK FAILED %0t read %h err %b exp %h", $time, got, gerr, n.exp);
      end
   endtask : chk_rd

   task automatic chk_lvl(input logic [31:0] got, input mdsio_note_t n);
      checks++;
      if (got !== n.exp) begin
         failures++;
         $display("CHECK FAILED %0t level %0d got %h exp %h", $time, n.sel, got, n.exp);
      end
   endtask : chk_lvl

   // reads are judged at the edge where the master samples pready
   always @(posedge sys_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && q_rd.size() > 0)
         chk_rd(prdata, pslverr, q_rd.pop_front());
   end

   always @(obs_ev) begin : mon
      mdsio_note_t n;
      n = q_lvl.pop_front();
      chk_lvl(obs(n.sel), n);
   end

   always @(posedge sys_clk) begin
      if (counting && shaft_angle_pulse === 1'b1 && pulse_d !== 1'b1) rises++;
      pulse_d <= shaft_angle_pulse;
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) failures++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
      q_rd.push_back('{0, e, err});
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd

   // pins pass a two-flop synchroniser, so five edges cover every path
   task automatic settle();
      repeat (5) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic look(input int s, input logic [31:0] e);
      q_lvl.push_back('{s, e, 1'b0});
      ->obs_ev;
      #1;
   endtask : look

   task automatic close_out();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out

   initial begin
      #2_000_000;
      failures++;
      close_out();
   end

   initial begin
      int pl[5];
      logic [31:0] r, w, v;
      logic [15:0] fb, ef;
      logic [5:0]  pol, din, eo;
      logic [3:0]  b;
      logic        pa, na;
      {rst, psel, penable, pwrite, step_evt, step_dir, home_op_active} = 7'h7f & 7'h40;
      {internal_busy, main_power_on, counting, pulse_d} = 4'h0;
      {paddr, pwdata, cmd_pos, act_pos, cmd_in_pins, direct_in_pins} = '0;
      {sw_act, sw_nc} = 8'h00;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      rd(OFS_CTRL, 32'(CTRL_RST), 1'b0);
      rd(8'hFC, 32'h0000_0000, 1'b1);
      for (int c = 0; c < 3; c++) begin
         for (int z = 0; z < 3; z++) begin
            apb(1'b1, 8'(OFS_ZONE + 8 * z), 32'(up_t[c]));
            apb(1'b1, 8'(OFS_ZONE + 8 * z + 4), 32'(lo_t[c]));
         end
         pl = '{lo_t[c] - 1, lo_t[c], up_t[c], up_t[c] + 1, $random(seed) % 200};
         for (int k = 0; k < 5; k++) begin
            @(posedge sys_clk);
            cmd_pos <= POS_W'(pl[k]);
            act_pos <= POS_W'(pl[(k + 2) % 5]);
            settle();
            v = {29'h0000_0000, zin(pl[(k + 2) % 5], up_t[c], lo_t[c]),
                 {2{zin(pl[k], up_t[c], lo_t[c])}}};
            look(0, v);
         end
      end
      for (int i = 0; i < 16; i++) begin
         r = $random(seed);
         b = 4'(i);
         pa = r[0];
         na = ~r[0] & r[9];
         apb(1'b1, OFS_CTRL, {25'h000_0000, r[6], r[5], r[4], r[3], b[2], b[1], b[0]});
         @(posedge sys_clk);
         sw_act <= {pa, na, r[1], r[2]};
         sw_nc <= {b[2], b[2], r[3], r[4]};
         home_op_active <= b[3];
         internal_busy <= r[7];
         main_power_on <= r[8];
         cmd_in_pins <= r[31:9];
         settle();
         look(2, 32'({pa ^ b[2], na ^ b[2], r[1] ^ r[3], r[2] ^ r[4]}));
         look(1, 32'(r[31:9]));
         w = 32'(b[0] & ~b[3] & (pa | na));
         look(3, {30'h0000_0000, w[0] & ~b[1], w[0] & b[1]});
         look(7, 32'({pa & b[3], na & b[3], r[1] & r[5], r[2]}));
         look(6, 32'({r[7] | r[6], r[8]}));
      end
      for (int t = 0; t < 2; t++) begin
         fb = 16'($random(seed));
         pol = 6'($random(seed));
         din = 6'($random(seed));
         w = 32'h0000_0000;
         v = 32'h0000_0000;
         ef = 16'h0000;
         for (int k = 0; k < 6; k++) begin
            w |= 32'(16 | (k + 5)) << (5 * k);
            v |= 32'(16 | (15 - k)) << (5 * k);
            eo[k] = fb[k + 5];
            ef[15 - k] = din[k] ^ pol[k];
         end
         apb(1'b1, OFS_FB_IN, 32'(fb));
         apb(1'b1, OFS_RT_OUT, w);
         apb(1'b1, OFS_RT_IN, v);
         apb(1'b1, OFS_IN_POL, 32'(pol));
         @(posedge sys_clk);
         direct_in_pins <= din;
         settle();
         look(5, 32'(eo));
         look(4, 32'(ef));
         rd(OFS_FB_OUT, 32'(ef), 1'b0);
      end
      @(posedge sys_clk);
      step_dir <= 1'b1;
      counting <= 1'b1;
      repeat (STEPS) begin
         @(posedge sys_clk);
         step_evt <= 1'b1;
         @(posedge sys_clk);
         step_evt <= 1'b0;
      end
      repeat (3) @(posedge sys_clk);
      counting <= 1'b0;
      settle();
      look(8, 32'(PULSES_REV));
      close_out();
   end
endmodule : test_motor_driver_status_and_sensor_io
